//--- core/fpp_defines.vh
// Constants for the flash program and erase pacer.
// Assumes a single 25 MHz clock and a byte-addressed register port.
`ifndef FPP_DEFINES_VH
`define FPP_DEFINES_VH

// Clock rate and the microsecond tick derived from it.
`define FPP_CLK_MHZ 25
`define FPP_US_CYCLES (`FPP_CLK_MHZ)
`define FPP_US_PER_MS 1000

// Widths of timer loads, the pulse-time total and the pass counter.
`define FPP_TW 14
`define FPP_AW 21
`define FPP_IW 9

// Program timing, in microseconds unless marked in milliseconds; the last two entries are pass counts.
`define FPP_T_UNLOCK_US 10
`define FPP_T_PSETUP_US 50
`define FPP_T_PPULSE_MIN_US 150
`define FPP_T_PPULSE_MAX_US 500
`define FPP_T_PPOST_US 10
`define FPP_T_PSU_OFF_US 10
`define FPP_T_PV_US 4
`define FPP_T_DUMMY_US 2
`define FPP_T_PV_OFF_US 4
`define FPP_T_PROG_TOTAL_MS 200
`define FPP_PROG_LIMIT 403
`define FPP_MIN_PULSE_PASSES 4

// Erase timing, in microseconds unless marked in milliseconds; the last entry is a pass count.
`define FPP_T_ESETUP_US 200
`define FPP_T_EPULSE_MIN_MS 5
`define FPP_T_EPULSE_MAX_MS 10
`define FPP_T_EPOST_US 10
`define FPP_T_ESU_OFF_US 10
`define FPP_T_EV_US 20
`define FPP_T_EV_OFF_US 5
`define FPP_T_ERASE_TOTAL_MS 1200
`define FPP_ERASE_LIMIT 120

// Register byte offsets.
`define FPP_REG_CTRL 8'h00
`define FPP_REG_PLEN 8'h04
`define FPP_REG_ELEN 8'h08
`define FPP_REG_PLIM 8'h0c
`define FPP_REG_ELIM 8'h10
`define FPP_REG_STAT 8'h14
`define FPP_REG_ITER 8'h18
`define FPP_REG_ACC 8'h1c

// Control and status bit positions.
`define FPP_CTRL_PROG 0
`define FPP_CTRL_ERASE 1
`define FPP_CTRL_ABORT 2
`define FPP_STAT_BUSY 0
`define FPP_STAT_DONE 1
`define FPP_STAT_FAIL 2
`define FPP_STAT_ERASE 3

`endif

//--- core/fpp_us_timer.v
// Microsecond wait timer for the flash pacer.
// Assumes load is a one-cycle pulse and the loaded value is nonzero.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_defines.vh"

module fpp_us_timer (
  input wire clk,
  input wire nrst,
  input wire load,
  input wire [`FPP_TW-1:0] load_us,
  output wire expired
);

  localparam [4:0] DIV_LAST = `FPP_US_CYCLES - 1;
  localparam [`FPP_TW-1:0] ONE_US = 14'h0001;

  reg [4:0] div_q;
  reg [`FPP_TW-1:0] cnt_q;

  // The divider restarts on every load, so N ticks are N whole microseconds.
  always @(posedge clk) begin
    if (!nrst) begin
      div_q <= 5'h00;
      cnt_q <= 14'h0000;
    end else if (load) begin
      div_q <= 5'h00;
      cnt_q <= load_us;
    end else if (cnt_q != 14'h0000) begin
      if (div_q == DIV_LAST) begin
        div_q <= 5'h00;
        cnt_q <= cnt_q - ONE_US;
      end else begin
        div_q <= div_q + 5'h01;
      end
    end
  end

  assign expired = (cnt_q == 14'h0000) && !load;

endmodule
`default_nettype wire

//--- core/fpp_pacer.v
// Flash program and erase pacer: drives the flash control bits in order.
// Assumes the flash answers a verify read in the cycle after flash_rd.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_defines.vh"

module fpp_pacer #(
  parameter ERASE_SETUP_US = `FPP_T_ESETUP_US,
  parameter ERASE_PULSE_MIN_US = `FPP_T_EPULSE_MIN_MS * `FPP_US_PER_MS,
  parameter ERASE_PULSE_MAX_US = `FPP_T_EPULSE_MAX_MS * `FPP_US_PER_MS,
  parameter PROG_PULSE_MAX_US = `FPP_T_PPULSE_MAX_US,
  parameter PROG_TOTAL_US = `FPP_T_PROG_TOTAL_MS * `FPP_US_PER_MS,
  parameter ERASE_TOTAL_US = `FPP_T_ERASE_TOTAL_MS * `FPP_US_PER_MS
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  output wire flash_write_unlock,
  output wire program_setup,
  output wire program_pulse,
  output wire write_verify,
  output wire clear_setup,
  output wire clear_pulse,
  output wire clear_verify,
  output wire flash_dummy_wr,
  output wire flash_rd,
  input wire flash_verify_ok,
  output wire busy,
  output wire done,
  output wire fail
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_UNLOCK = 4'h1;
  localparam [3:0] S_CHECK = 4'h2;
  localparam [3:0] S_SETUP = 4'h3;
  localparam [3:0] S_PULSE = 4'h4;
  localparam [3:0] S_PULSE_OFF = 4'h5;
  localparam [3:0] S_SETUP_OFF = 4'h6;
  localparam [3:0] S_VERIFY = 4'h7;
  localparam [3:0] S_DUMMY = 4'h8;
  localparam [3:0] S_READ = 4'h9;
  localparam [3:0] S_VERIFY_OFF = 4'ha;

  localparam [`FPP_TW-1:0] T_UNLOCK = `FPP_T_UNLOCK_US;
  localparam [`FPP_TW-1:0] T_PSETUP = `FPP_T_PSETUP_US;
  localparam [`FPP_TW-1:0] T_PMIN = `FPP_T_PPULSE_MIN_US;
  localparam [`FPP_TW-1:0] T_PMAX = PROG_PULSE_MAX_US[`FPP_TW-1:0];
  localparam [`FPP_TW-1:0] T_PPOST = `FPP_T_PPOST_US;
  localparam [`FPP_TW-1:0] T_PSU_OFF = `FPP_T_PSU_OFF_US;
  localparam [`FPP_TW-1:0] T_PV = `FPP_T_PV_US;
  localparam [`FPP_TW-1:0] T_DUMMY = `FPP_T_DUMMY_US;
  localparam [`FPP_TW-1:0] T_PV_OFF = `FPP_T_PV_OFF_US;
  localparam [`FPP_TW-1:0] T_ESETUP = ERASE_SETUP_US[`FPP_TW-1:0];
  localparam [`FPP_TW-1:0] T_EMIN = ERASE_PULSE_MIN_US[`FPP_TW-1:0];
  localparam [`FPP_TW-1:0] T_EMAX = ERASE_PULSE_MAX_US[`FPP_TW-1:0];
  localparam [`FPP_TW-1:0] T_EPOST = `FPP_T_EPOST_US;
  localparam [`FPP_TW-1:0] T_ESU_OFF = `FPP_T_ESU_OFF_US;
  localparam [`FPP_TW-1:0] T_EV = `FPP_T_EV_US;
  localparam [`FPP_TW-1:0] T_EV_OFF = `FPP_T_EV_OFF_US;
  localparam [`FPP_AW-1:0] PROG_TOTAL = PROG_TOTAL_US[`FPP_AW-1:0];
  localparam [`FPP_AW-1:0] ERASE_TOTAL = ERASE_TOTAL_US[`FPP_AW-1:0];
  localparam [`FPP_IW-1:0] PROG_LIMIT = `FPP_PROG_LIMIT;
  localparam [`FPP_IW-1:0] ERASE_LIMIT = `FPP_ERASE_LIMIT;
  localparam [`FPP_IW-1:0] MIN_PASSES = `FPP_MIN_PULSE_PASSES;

  // Holds a value between two bounds.
  function [`FPP_TW-1:0] fpp_clamp;
    input [`FPP_TW-1:0] v;
    input [`FPP_TW-1:0] lo;
    input [`FPP_TW-1:0] hi;
    begin
      fpp_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  reg [3:0] state_q;
  reg erase_q;
  reg unlock_q;
  reg setup_q;
  reg pulse_q;
  reg verify_q;
  reg dummy_q;
  reg rd_q;
  reg rd_dly_q;
  reg ok_q;
  reg done_q;
  reg fail_q;
  reg tmr_load_q;
  reg [`FPP_TW-1:0] tmr_val_q;
  reg [`FPP_TW-1:0] plen_q;
  reg [`FPP_TW-1:0] elen_q;
  reg [`FPP_IW-1:0] plim_q;
  reg [`FPP_IW-1:0] elim_q;
  reg [`FPP_IW-1:0] iter_q;
  reg [`FPP_AW-1:0] acc_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  wire tmr_exp;
  wire wr_ctrl;
  wire start_prog;
  wire start_erase;
  wire abort_req;
  wire [`FPP_TW-1:0] pass_len;
  wire [`FPP_AW-1:0] acc_next;
  wire [`FPP_TW-1:0] plim_fit;
  wire [`FPP_TW-1:0] elim_fit;
  wire limit_hit;

  fpp_us_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .load(tmr_load_q),
    .load_us(tmr_val_q),
    .expired(tmr_exp)
  );

  assign wr_ctrl = reg_wr && (reg_addr == `FPP_REG_CTRL);
  assign start_prog = wr_ctrl && reg_wdata[`FPP_CTRL_PROG];
  assign start_erase = wr_ctrl && reg_wdata[`FPP_CTRL_ERASE];
  assign abort_req = wr_ctrl && reg_wdata[`FPP_CTRL_ABORT];

  // Early program passes are forced to the shortest pulse.
  assign pass_len = erase_q ? elen_q :
    ((iter_q < MIN_PASSES) ? T_PMIN : plen_q);
  assign acc_next = acc_q + {{(`FPP_AW - `FPP_TW){1'h0}}, pass_len};
  // A pass is refused if it would break the count or the total pulse time.
  assign limit_hit = (iter_q >= (erase_q ? elim_q : plim_q)) ||
    (acc_next > (erase_q ? ERASE_TOTAL : PROG_TOTAL));
  assign plim_fit = fpp_clamp({5'h00, reg_wdata[`FPP_IW-1:0]}, 14'h0001,
    {5'h00, PROG_LIMIT});
  assign elim_fit = fpp_clamp({5'h00, reg_wdata[`FPP_IW-1:0]}, 14'h0001,
    {5'h00, ERASE_LIMIT});

  // Configuration registers; lengths and limits are held inside bounds.
  always @(posedge clk) begin
    if (!nrst) begin
      plen_q <= T_PMIN;
      elen_q <= T_EMAX;
      plim_q <= PROG_LIMIT;
      elim_q <= ERASE_LIMIT;
    end else if (reg_wr) begin
      case (reg_addr)
        `FPP_REG_PLEN: begin
          plen_q <= fpp_clamp(reg_wdata[`FPP_TW-1:0], T_PMIN, T_PMAX);
        end
        `FPP_REG_ELEN: begin
          elen_q <= fpp_clamp(reg_wdata[`FPP_TW-1:0], T_EMIN, T_EMAX);
        end
        `FPP_REG_PLIM: plim_q <= plim_fit[`FPP_IW-1:0];
        `FPP_REG_ELIM: elim_q <= elim_fit[`FPP_IW-1:0];
        default: plen_q <= plen_q;
      endcase
    end
  end

  // Sequencer: each wait is timed from the edge after the one on which the bits changed.
  always @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      erase_q <= 1'h0;
      unlock_q <= 1'h0;
      setup_q <= 1'h0;
      pulse_q <= 1'h0;
      verify_q <= 1'h0;
      dummy_q <= 1'h0;
      rd_q <= 1'h0;
      rd_dly_q <= 1'h0;
      ok_q <= 1'h0;
      done_q <= 1'h0;
      fail_q <= 1'h0;
      tmr_load_q <= 1'h0;
      tmr_val_q <= 14'h0000;
      iter_q <= 9'h000;
      acc_q <= 21'h000000;
    end else begin
      tmr_load_q <= 1'h0;
      dummy_q <= 1'h0;
      rd_q <= 1'h0;
      rd_dly_q <= rd_q;
      // Abort and a refused pass both end the operation with every bit off.
      if ((abort_req && (state_q != S_IDLE)) ||
        ((state_q == S_CHECK) && limit_hit)) begin
        state_q <= S_IDLE;
        unlock_q <= 1'h0;
        setup_q <= 1'h0;
        pulse_q <= 1'h0;
        verify_q <= 1'h0;
        fail_q <= 1'h1;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (start_prog || start_erase) begin
              erase_q <= !start_prog;
              unlock_q <= 1'h1;
              done_q <= 1'h0;
              fail_q <= 1'h0;
              iter_q <= 9'h000;
              acc_q <= 21'h000000;
              tmr_load_q <= 1'h1;
              tmr_val_q <= T_UNLOCK;
              state_q <= S_UNLOCK;
            end
          end
          S_UNLOCK: begin
            if (tmr_exp) state_q <= S_CHECK;
          end
          S_CHECK: begin
            setup_q <= 1'h1;
            tmr_load_q <= 1'h1;
            tmr_val_q <= erase_q ? T_ESETUP : T_PSETUP;
            state_q <= S_SETUP;
          end
          S_SETUP: begin
            if (tmr_exp) begin
              pulse_q <= 1'h1;
              iter_q <= iter_q + 9'h001;
              acc_q <= acc_next;
              tmr_load_q <= 1'h1;
              tmr_val_q <= pass_len;
              state_q <= S_PULSE;
            end
          end
          S_PULSE: begin
            if (tmr_exp) begin
              pulse_q <= 1'h0;
              tmr_load_q <= 1'h1;
              tmr_val_q <= erase_q ? T_EPOST : T_PPOST;
              state_q <= S_PULSE_OFF;
            end
          end
          S_PULSE_OFF: begin
            if (tmr_exp) begin
              setup_q <= 1'h0;
              tmr_load_q <= 1'h1;
              tmr_val_q <= erase_q ? T_ESU_OFF : T_PSU_OFF;
              state_q <= S_SETUP_OFF;
            end
          end
          S_SETUP_OFF: begin
            if (tmr_exp) begin
              verify_q <= 1'h1;
              tmr_load_q <= 1'h1;
              tmr_val_q <= erase_q ? T_EV : T_PV;
              state_q <= S_VERIFY;
            end
          end
          S_VERIFY: begin
            if (tmr_exp) begin
              dummy_q <= 1'h1;
              tmr_load_q <= 1'h1;
              tmr_val_q <= T_DUMMY;
              state_q <= S_DUMMY;
            end
          end
          S_DUMMY: begin
            if (tmr_exp) begin
              rd_q <= 1'h1;
              state_q <= S_READ;
            end
          end
          S_READ: begin
            // The read answer stands in the cycle after the read strobe.
            if (rd_dly_q) begin
              ok_q <= flash_verify_ok;
              verify_q <= 1'h0;
              tmr_load_q <= 1'h1;
              tmr_val_q <= erase_q ? T_EV_OFF : T_PV_OFF;
              state_q <= S_VERIFY_OFF;
            end
          end
          S_VERIFY_OFF: begin
            if (tmr_exp) begin
              if (ok_q) begin
                unlock_q <= 1'h0;
                done_q <= 1'h1;
                state_q <= S_IDLE;
              end else begin
                state_q <= S_CHECK;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            unlock_q <= 1'h0;
            setup_q <= 1'h0;
            pulse_q <= 1'h0;
            verify_q <= 1'h0;
          end
        endcase
      end
    end
  end

  // Register read port; data stands only in the cycle after the strobe.
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `FPP_REG_PLEN: rdata_d[`FPP_TW-1:0] = plen_q;
      `FPP_REG_ELEN: rdata_d[`FPP_TW-1:0] = elen_q;
      `FPP_REG_PLIM: rdata_d[`FPP_IW-1:0] = plim_q;
      `FPP_REG_ELIM: rdata_d[`FPP_IW-1:0] = elim_q;
      `FPP_REG_STAT: begin
        rdata_d[`FPP_STAT_BUSY] = (state_q != S_IDLE);
        rdata_d[`FPP_STAT_DONE] = done_q;
        rdata_d[`FPP_STAT_FAIL] = fail_q;
        rdata_d[`FPP_STAT_ERASE] = erase_q;
      end
      `FPP_REG_ITER: rdata_d[`FPP_IW-1:0] = iter_q;
      `FPP_REG_ACC: rdata_d[`FPP_AW-1:0] = acc_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst || !reg_rd) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign flash_write_unlock = unlock_q;
  assign program_setup = setup_q && !erase_q;
  assign program_pulse = pulse_q && !erase_q;
  assign write_verify = verify_q && !erase_q;
  assign clear_setup = setup_q && erase_q;
  assign clear_pulse = pulse_q && erase_q;
  assign clear_verify = verify_q && erase_q;
  assign flash_dummy_wr = dummy_q;
  assign flash_rd = rd_q;
  assign busy = (state_q != S_IDLE);
  assign done = done_q;
  assign fail = fail_q;

endmodule
`default_nettype wire

//--- verification/fpp_pacer_checker.sv
// Timing checker for the flash pacer, bound to its top module.
// Assumes a 25 MHz clock and the pacer's own timing parameters.
`timescale 1ns/1ps
`default_nettype none
module fpp_pacer_checker #(
  parameter ERASE_SETUP_US = 200,
  parameter ERASE_PULSE_MIN_US = 5000,
  parameter ERASE_PULSE_MAX_US = 10000,
  parameter PROG_PULSE_MAX_US = 500
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flash_write_unlock,
  input wire logic program_setup,
  input wire logic program_pulse,
  input wire logic write_verify,
  input wire logic clear_setup,
  input wire logic clear_pulse,
  input wire logic clear_verify,
  input wire logic flash_dummy_wr,
  input wire logic flash_rd,
  input wire logic busy,
  input wire logic fail
);
  localparam int US = 25;
  logic su, pl, vf, su_p, pl_p, vf_p, un_p, er_q;
  logic [19:0] c_un, c_su, c_pl, c_vf, c_dw;
  logic [3:0] n_pl;
  assign su = program_setup | clear_setup;
  assign pl = program_pulse | clear_pulse;
  assign vf = write_verify | clear_verify;
  // Each counter holds the cycles since its last event, saturating.
  function automatic logic [19:0] nx(logic ev, logic [19:0] c);
    return ev ? 20'h0 : (&c ? c : c + 20'h1);
  endfunction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {c_un, c_su, c_pl, c_vf, c_dw} <= '1;
      {su_p, pl_p, vf_p, un_p, er_q} <= '0;
      n_pl <= '0;
    end else begin
      c_un <= nx(flash_write_unlock & ~un_p, c_un);
      c_su <= nx(su ^ su_p, c_su);
      c_pl <= nx(pl ^ pl_p, c_pl);
      c_vf <= nx(vf ^ vf_p, c_vf);
      c_dw <= nx(flash_dummy_wr, c_dw);
      {su_p, pl_p, vf_p, un_p} <= {su, pl, vf, flash_write_unlock};
      if (clear_setup) er_q <= 1'b1;
      else if (program_setup) er_q <= 1'b0;
      if (!flash_write_unlock) n_pl <= '0;
      else if (program_pulse & ~pl_p & ~&n_pl) n_pl <= n_pl + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_in_verify;
    vf && !pl && !su;
  endsequence
  property p_unlock; $rose(su) |-> c_un >= 10 * US - 1; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock wait short");
  property p_setup;
    $rose(pl) |-> c_su >= (program_setup ? 50 : ERASE_SETUP_US) * US - 1;
  endproperty
  a_setup: assert property (p_setup) else $error("setup wait short");
  property p_plen;
    $fell(program_pulse) |-> if (n_pl <= 4'd4) c_pl == 150 * US + 1
      else (c_pl >= 150 * US - 1 && c_pl <= PROG_PULSE_MAX_US * US + 1);
  endproperty
  a_plen: assert property (p_plen) else $error("program pulse length");
  property p_elen;
    $fell(clear_pulse) |-> c_pl >= ERASE_PULSE_MIN_US * US - 1
      && c_pl <= ERASE_PULSE_MAX_US * US + 1;
  endproperty
  a_elen: assert property (p_elen) else $error("erase pulse length");
  property p_post; $fell(su) |-> c_pl >= 10 * US - 1; endproperty
  a_post: assert property (p_post) else $error("setup off early");
  property p_pre; $rose(vf) |-> c_su >= 10 * US - 1; endproperty
  a_pre: assert property (p_pre) else $error("verify on early");
  property p_dummy;
    $rose(flash_dummy_wr) |-> c_vf >= (clear_verify ? 20 : 4) * US - 1;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy early");
  property p_read; $rose(flash_rd) |-> c_dw >= 2 * US - 1; endproperty
  a_read: assert property (p_read) else $error("read early");
  property p_after;
    $rose(su) || $fell(flash_write_unlock) |-> c_vf >= (er_q ? 5 : 4) * US - 1;
  endproperty
  a_after: assert property (p_after) else $error("verify off wait");
  property p_order; flash_rd |-> s_in_verify ##[1:2] !vf; endproperty
  a_order: assert property (p_order) else $error("pass order");
  property p_fail;
    fail && !busy |-> !(flash_write_unlock | su | pl | vf);
  endproperty
  a_fail: assert property (p_fail) else $error("bits on after fail");
endmodule
bind fpp_pacer fpp_pacer_checker #(.ERASE_SETUP_US(ERASE_SETUP_US),
  .ERASE_PULSE_MIN_US(ERASE_PULSE_MIN_US),
  .ERASE_PULSE_MAX_US(ERASE_PULSE_MAX_US),
  .PROG_PULSE_MAX_US(PROG_PULSE_MAX_US)) u_chk (.clk(clk), .nrst(nrst),
  .flash_write_unlock(flash_write_unlock), .program_setup(program_setup),
  .program_pulse(program_pulse), .write_verify(write_verify),
  .clear_setup(clear_setup), .clear_pulse(clear_pulse),
  .clear_verify(clear_verify), .flash_dummy_wr(flash_dummy_wr),
  .flash_rd(flash_rd), .busy(busy), .fail(fail));
`default_nettype wire

//--- verification/fpp_flash_model.sv
// Flash array model: answers verify reads and totals pulse time.
// Assumes a verify read is answered in the cycle after flash_rd.
`timescale 1ns/1ps
`default_nettype none
module fpp_flash_model #(
  parameter int PROG_TOTAL_US = 200000,
  parameter int ERASE_TOTAL_US = 1200000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flash_write_unlock,
  input wire logic program_pulse,
  input wire logic clear_pulse,
  input wire logic flash_rd,
  input wire logic [8:0] fails,
  output logic flash_verify_ok,
  output logic over
);
  logic [8:0] reads_q;
  logic [25:0] acc_q;
  logic rd_q, junk_q, ers_q;
  always_ff @(posedge clk) begin
    rd_q <= flash_rd;
    junk_q <= ~junk_q & nrst;
    if (!nrst || !flash_write_unlock) begin
      reads_q <= '0;
      acc_q <= '0;
      ers_q <= 1'b0;
    end else begin
      if (clear_pulse) ers_q <= 1'b1;
      if (program_pulse | clear_pulse) acc_q <= acc_q + 26'h1;
      if (flash_rd) reads_q <= reads_q + 9'h1;
    end
    if (!nrst) over <= 1'b0;
    else if (acc_q > (ers_q ? ERASE_TOTAL_US : PROG_TOTAL_US) * 25 + 128)
      over <= 1'b1;
  end
  // Outside the answer cycle the line toggles so a stale value never passes.
  assign flash_verify_ok = rd_q ? (reads_q > fails) : junk_q;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the flash pacer with a flash model beside it.
// Assumes a 25 MHz clock and shortened erase timing parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [8:0] fails = '0;
  wire [31:0] reg_rdata;
  wire flash_write_unlock, program_setup, program_pulse, write_verify;
  wire clear_setup, clear_pulse, clear_verify, flash_dummy_wr, flash_rd;
  wire flash_verify_ok, busy, done, fail, over;
  int err_count = 0, check_count = 0;
  always #20 clk = ~clk;
  fpp_pacer #(.ERASE_SETUP_US(20), .ERASE_PULSE_MIN_US(50),
    .ERASE_PULSE_MAX_US(100), .ERASE_TOTAL_US(500)) dut (.clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_write_unlock(flash_write_unlock), .program_setup(program_setup),
    .program_pulse(program_pulse), .write_verify(write_verify),
    .clear_setup(clear_setup), .clear_pulse(clear_pulse),
    .clear_verify(clear_verify), .flash_dummy_wr(flash_dummy_wr),
    .flash_rd(flash_rd), .flash_verify_ok(flash_verify_ok), .busy(busy),
    .done(done), .fail(fail));
  fpp_flash_model #(.ERASE_TOTAL_US(500)) m_flash (
    .clk(clk), .nrst(nrst), .flash_write_unlock(flash_write_unlock),
    .program_pulse(program_pulse), .clear_pulse(clear_pulse),
    .flash_rd(flash_rd), .fails(fails), .flash_verify_ok(flash_verify_ok),
    .over(over));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, reg_rdata, exp);
    @(posedge clk);
  endtask
  // Starts an operation and waits, bounded, until the pacer is idle again.
  task automatic run(logic [31:0] ctl, logic [1:0] df);
    wr(8'h00, ctl);
    @(negedge clk);
    for (int i = 0; i < 60000 && busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    chk("idle", {31'h0, busy}, 32'h0);
    chk("done fail pins", {30'h0, done, fail}, {30'h0, df});
    @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h0c, 32'd403, "plim");
    rd(8'h10, 32'd120, "elim");
    rd(8'h04, 32'd150, "plen");
    rd(8'h20, 32'h0, "unmapped");
    wr(8'h04, 32'd600);
    rd(8'h04, 32'd500, "plen max");
    wr(8'h08, 32'd1);
    rd(8'h08, 32'd50, "elen min");
    wr(8'h0c, 32'd500);
    rd(8'h0c, 32'd403, "plim max");
    wr(8'h10, 32'd0);
    rd(8'h10, 32'd1, "elim min");
    wr(8'h10, 32'd200);
    rd(8'h10, 32'd120, "elim max");
    run(32'h3, 2'b10);
    rd(8'h14, 32'h2, "prog ok");
    rd(8'h18, 32'd1, "prog passes");
    rd(8'h1c, 32'd150, "prog time");
    fails <= 9'h1ff;
    wr(8'h0c, 32'd5);
    run(32'h1, 2'b01);
    rd(8'h14, 32'h4, "prog fail");
    rd(8'h18, 32'd5, "prog limit");
    rd(8'h1c, 32'd1100, "prog pulses");
    fails <= 9'd2;
    run(32'h2, 2'b10);
    rd(8'h14, 32'ha, "erase ok");
    rd(8'h18, 32'd3, "erase passes");
    rd(8'h1c, 32'd150, "erase time");
    fails <= 9'h1ff;
    wr(8'h08, 32'd100);
    run(32'h2, 2'b01);
    rd(8'h14, 32'hc, "erase fail");
    rd(8'h18, 32'd5, "erase total");
    rd(8'h1c, 32'd500, "erase sum");
    wr(8'h00, 32'h1);
    repeat (50) @(posedge clk);
    wr(8'h00, 32'h4);
    @(posedge clk);
    rd(8'h14, 32'h4, "abort");
    chk("pulse total", {31'h0, over}, 32'h0);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
